// ---- include/adsq_params.svh ----
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADSQ_PARAMS_SVH
`define ADSQ_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define ADSQ_ADDR_CR1 8'h0e
`define ADSQ_ADDR_CR2 8'h0f
`define ADSQ_ADDR_DR2 8'h1e
`define ADSQ_ADDR_DR1 8'h1f

// ==========================================================
// Reset values
`define ADSQ_CR1_RESET 8'h00
`define ADSQ_CR2_RESET 6'h00

// ==========================================================
// Field positions
`define ADSQ_CR1_START 7
`define ADSQ_CR1_MODE_HI 6
`define ADSQ_CR1_MODE_LO 5
`define ADSQ_CR1_INDIS 4
`define ADSQ_CR2_LADDER 5
`define ADSQ_CR2_TSEL_HI 3
`define ADSQ_CR2_TSEL_LO 1
`define ADSQ_DR2_END 5
`define ADSQ_DR2_BUSY 4

// ==========================================================
// Operation mode codes
`define ADSQ_MODE_OFF 2'b00
`define ADSQ_MODE_SOFT 2'b01
`define ADSQ_MODE_REPEAT 2'b11

// ==========================================================
// Timing: shortest conversion in system clock cycles, sample phase in steps
`define ADSQ_CONV_FC_MIN 39
`define ADSQ_SAMPLE_TICKS 3
`define ADSQ_RES_BITS 10

`endif

// ---- include/adsq_pkg.sv ----
// Types shared by the converter control modules
package adsq_pkg;

    // SAR engine states
    typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_CONVERT} adsq_sar_state_t;

endpackage

// ---- rtl/adsq_step_timer.sv ----
// Step tick generator that paces the sample and bit phases of a conversion
`timescale 1ns/10ps
`include "adsq_params.svh"
module adsq_step_timer import adsq_pkg::*; #(
    parameter int CNT_W = 7
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [2:0] sel,
    output logic tick
);
    // Cycles per step at the fastest setting: one conversion is sample plus bit steps
    localparam int BASE = `ADSQ_CONV_FC_MIN / (`ADSQ_SAMPLE_TICKS + `ADSQ_RES_BITS);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] period;

    generate
        if (CNT_W < 7)
        begin : g_chk
            $error("adsq_step_timer: CNT_W too small for slowest setting");
        end
    endgenerate

    // Time select to doubling count; reserved codes fall back to the slowest
    function automatic logic [2:0] tsel_shift(input logic [2:0] s);
        case (s)
            3'h0: tsel_shift = 3'h0;
            3'h2: tsel_shift = 3'h1;
            3'h3: tsel_shift = 3'h2;
            3'h4: tsel_shift = 3'h3;
            3'h5: tsel_shift = 3'h4;
            default: tsel_shift = 3'h5;
        endcase
    endfunction

    assign period = CNT_W'(BASE) << tsel_shift(sel);

    // Free count while running, held at zero otherwise so each step is full length
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt_q <= '0;
            tick <= 1'b0;
        end
        else if (cnt_q == period - CNT_W'(1))
        begin
            cnt_q <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + CNT_W'(1);
            tick <= 1'b0;
        end
    end
endmodule

// ---- rtl/adsq_sar_engine.sv ----
// Successive-approximation sequencer driving the DAC code from comparator decisions
`timescale 1ns/10ps
`include "adsq_params.svh"
module adsq_sar_engine import adsq_pkg::*; #(
    parameter int RES_W = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic tick,
    input wire logic comp,
    output logic busy,
    output logic sample,
    output logic [RES_W-1:0] dac_code,
    output logic done,
    output logic [RES_W-1:0] result
);
    adsq_sar_state_t state_q;
    logic [1:0] scnt_q;
    logic [3:0] bitn_q;
    logic [RES_W-1:0] trial;

    generate
        if (RES_W < 2 || RES_W > 16)
        begin : g_chk
            $error("adsq_sar_engine: RES_W out of range");
        end
    endgenerate

    // Current trial with the bit under test dropped when the input is below it
    always_comb
    begin
        trial = dac_code;
        if (!comp)
        begin
            trial[bitn_q] = 1'b0;
        end
    end

    // Abort wins over everything but reset, so a partial code never reaches the result
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= SAR_IDLE;
            scnt_q <= 2'h0;
            bitn_q <= 4'h0;
            busy <= 1'b0;
            sample <= 1'b0;
            dac_code <= '0;
            done <= 1'b0;
            result <= '0;
        end
        else if (abort)
        begin
            state_q <= SAR_IDLE;
            busy <= 1'b0;
            sample <= 1'b0;
            dac_code <= '0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            unique case (state_q)
                SAR_IDLE:
                begin
                    if (start)
                    begin
                        state_q <= SAR_SAMPLE;
                        scnt_q <= 2'h0;
                        busy <= 1'b1;
                        sample <= 1'b1;
                    end
                end
                SAR_SAMPLE:
                begin
                    if (tick && scnt_q == 2'(`ADSQ_SAMPLE_TICKS - 1))
                    begin
                        state_q <= SAR_CONVERT;
                        sample <= 1'b0;
                        bitn_q <= 4'(RES_W - 1);
                        dac_code <= RES_W'(1) << (RES_W - 1);
                    end
                    else if (tick)
                    begin
                        scnt_q <= scnt_q + 2'h1;
                    end
                end
                SAR_CONVERT:
                begin
                    if (tick && bitn_q == 4'h0)
                    begin
                        state_q <= SAR_IDLE;
                        result <= trial;
                        done <= 1'b1;
                        busy <= 1'b0;
                        dac_code <= '0;
                    end
                    else if (tick)
                    begin
                        dac_code <= trial | (RES_W'(1) << (bitn_q - 4'h1));
                        bitn_q <= bitn_q - 4'h1;
                    end
                end
            endcase
        end
    end
endmodule

// ---- rtl/adsq_top.sv ----
// Converter control: registers, start and repeat sequencing, result capture, standby handling
//
// Function
// - Standby entry abandons a running conversion at once.
// - Standby entry returns both control registers to reset values.
// - A conversion cut by standby leaves no valid result.
// - Earlier results are lost on standby; software reads them first.
// - After standby the converter stays idle until software starts it again.
// - In standby the reference ladder is disconnected without software action.
// - Each conversion gives an unsigned ten-bit result of the input.
// - Writing one to bit 7 of control one starts a conversion; here only in mode 01 or 11 and while idle.
// - The end flag is readable at any time for polling.
// - Upper 8 result bits in one register, lower 2 beside the flags.
// - Interrupt latch may be lost; the end flag keeps completion evidence.
// - Writing mode 00 stops conversion at once and discards the partial result.
// - The start bit clears itself once the conversion has begun.
// - Reading the upper result register clears the end flag.
// - Busy sets at start, clears at finish and on standby entry.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "adsq_params.svh"
module adsq_top import adsq_pkg::*; #(
    parameter int RES_W = `ADSQ_RES_BITS
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic STANDBY,
    input wire logic COMP,
    output logic [3:0] CH_SEL,
    output logic AIN_DISABLE,
    output logic [RES_W-1:0] DAC_CODE,
    output logic SAMPLE,
    output logic LADDER_ON,
    output logic DONE_IRQ
);
    // ==========================================================
    // Declarations

    // Control one fields
    logic start_q;
    logic [1:0] mode_q;
    logic indis_q;
    logic [3:0] chan_q;
    // Control two, bits 5..0 kept
    logic [5:0] cr2_q;
    // Result and flags
    logic [RES_W-1:0] res_q;
    logic end_q;
    logic restart_q;
    logic ladder_q;
    logic irq_q;
    logic [7:0] rdata_q;

    logic wr_cr1;
    logic wr_cr2;
    logic rd_dr1;
    logic kick;
    logic sar_start;
    logic sar_abort;
    logic sar_busy;
    logic sar_done;
    logic [RES_W-1:0] sar_result;
    logic tick;
    logic mode_runs;

    generate
        if (RES_W != 10)
        begin : g_chk
            $error("adsq_top: result split needs exactly ten bits");
        end
    endgenerate

    // Address match, shared by all strobe decodes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    // ==========================================================
    // Strobe decode

    // Writes are refused while standby holds the block in reset
    assign wr_cr1 = WR && hit(ADDR, `ADSQ_ADDR_CR1) && !STANDBY;
    assign wr_cr2 = WR && hit(ADDR, `ADSQ_ADDR_CR2) && !STANDBY;
    assign rd_dr1 = RD && hit(ADDR, `ADSQ_ADDR_DR1);
    assign mode_runs = (mode_q == `ADSQ_MODE_SOFT) || (mode_q == `ADSQ_MODE_REPEAT);

    // ==========================================================
    // Control register one

    // Fields follow the write; standby forces reset values
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            mode_q <= 2'(`ADSQ_CR1_RESET >> `ADSQ_CR1_MODE_LO);
            indis_q <= 1'b0;
            chan_q <= 4'h0;
        end
        else if (STANDBY)
        begin
            mode_q <= `ADSQ_MODE_OFF;
            indis_q <= 1'b0;
            chan_q <= 4'h0;
        end
        else if (wr_cr1)
        begin
            mode_q <= WDATA[`ADSQ_CR1_MODE_HI:`ADSQ_CR1_MODE_LO];
            indis_q <= WDATA[`ADSQ_CR1_INDIS];
            chan_q <= WDATA[3:0];
        end
    end

    // Start bit; a start written during a conversion is not honoured
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            start_q <= 1'b0;
        end
        else if (STANDBY)
        begin
            start_q <= 1'b0;
        end
        else if (wr_cr1)
        begin
            start_q <= WDATA[`ADSQ_CR1_START];
        end
        else
        begin
            start_q <= 1'b0;
        end
    end

    // ==========================================================
    // Control register two

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            cr2_q <= `ADSQ_CR2_RESET;
        end
        else if (STANDBY)
        begin
            cr2_q <= `ADSQ_CR2_RESET;
        end
        else if (wr_cr2)
        begin
            cr2_q <= WDATA[5:0];
        end
    end

    // ==========================================================
    // Conversion sequencing

    // A fresh start only in a running mode and only from idle
    assign kick = start_q && mode_runs && !sar_busy;
    assign sar_start = kick || restart_q;
    // Standby or a disable write kill the conversion before any result lands
    assign sar_abort = STANDBY || (wr_cr1 && WDATA[`ADSQ_CR1_MODE_HI:`ADSQ_CR1_MODE_LO] == `ADSQ_MODE_OFF);

    // Repeat mode chains the next conversion one cycle after completion
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            restart_q <= 1'b0;
        end
        else
        begin
            restart_q <= sar_done && mode_q == `ADSQ_MODE_REPEAT && !sar_abort;
        end
    end

    adsq_step_timer #(
        .CNT_W(7)
    ) u_timer (
        .clk(CLK),
        .rst(RST),
        .run(sar_busy),
        .sel(cr2_q[`ADSQ_CR2_TSEL_HI:`ADSQ_CR2_TSEL_LO]),
        .tick(tick)
    );

    adsq_sar_engine #(
        .RES_W(RES_W)
    ) u_sar (
        .clk(CLK),
        .rst(RST),
        .start(sar_start),
        .abort(sar_abort),
        .tick(tick),
        .comp(COMP),
        .busy(sar_busy),
        .sample(SAMPLE),
        .dac_code(DAC_CODE),
        .done(sar_done),
        .result(sar_result)
    );

    // ==========================================================
    // Result and end flag

    // Standby wipes old results; a finished conversion beats a clearing read
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            res_q <= '0;
        end
        else if (STANDBY)
        begin
            res_q <= '0;
        end
        else if (sar_done)
        begin
            res_q <= sar_result;
        end
    end

    // The interrupt does not touch this flag, so polling still sees completion
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            end_q <= 1'b0;
        end
        else if (STANDBY)
        begin
            end_q <= 1'b0;
        end
        else if (sar_done)
        begin
            end_q <= 1'b1;
        end
        else if (rd_dr1 || kick)
        begin
            end_q <= 1'b0;
        end
    end

    // One-cycle completion request to the interrupt controller
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= sar_done && !STANDBY;
        end
    end

    // ==========================================================
    // Reference ladder

    // Held on only while converting unless software keeps it on; off from the cycle after standby rises
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ladder_q <= 1'b0;
        end
        else
        begin
            ladder_q <= !STANDBY && (cr2_q[`ADSQ_CR2_LADDER] || sar_busy || sar_start);
        end
    end

    // ==========================================================
    // Read port

    // Data stand for exactly one cycle after the strobe; low status bits read zero
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            rdata_q <= 8'h00;
        end
        else if (!RD)
        begin
            rdata_q <= 8'h00;
        end
        else if (hit(ADDR, `ADSQ_ADDR_CR1))
        begin
            rdata_q <= {start_q, mode_q, indis_q, chan_q};
        end
        else if (hit(ADDR, `ADSQ_ADDR_CR2))
        begin
            rdata_q <= {2'b00, cr2_q};
        end
        else if (hit(ADDR, `ADSQ_ADDR_DR1))
        begin
            rdata_q <= res_q[9:2];
        end
        else if (hit(ADDR, `ADSQ_ADDR_DR2))
        begin
            rdata_q <= {res_q[1:0], end_q, sar_busy, 4'h0};
        end
        else
        begin
            rdata_q <= 8'h00;
        end
    end

    // ==========================================================
    // Outputs

    assign RDATA = rdata_q;
    assign CH_SEL = chan_q;
    assign AIN_DISABLE = indis_q;
    assign LADDER_ON = ladder_q;
    assign DONE_IRQ = irq_q;

    // ==========================================================
    // Assertions

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_standby_abort: assert property (STANDBY |=> !sar_busy && !SAMPLE && !sar_done)
        else $error("conversion survived standby");
    chk_standby_regs: assert property (STANDBY |=> mode_q == `ADSQ_MODE_OFF && cr2_q == `ADSQ_CR2_RESET)
        else $error("control registers not reset by standby");
    chk_standby_result: assert property (STANDBY |=> res_q == '0 && !end_q ##1 !DONE_IRQ)
        else $error("result survived standby");
    chk_no_restart: assert property ($fell(STANDBY) |-> !sar_busy ##1 !sar_busy)
        else $error("conversion restarted after standby");
    chk_ladder_off: assert property (STANDBY |=> !LADDER_ON)
        else $error("ladder connected in standby");
    chk_poll_flag: assert property (RD && hit(ADDR, `ADSQ_ADDR_DR2) |=> RDATA[`ADSQ_DR2_END] == $past(end_q))
        else $error("end flag read mismatch");
    chk_split_upper: assert property (RD && hit(ADDR, `ADSQ_ADDR_DR1) |=> RDATA == $past(res_q[9:2]))
        else $error("upper result read mismatch");
    chk_mode_abort: assert property (wr_cr1 && WDATA[6:5] == `ADSQ_MODE_OFF |=> !sar_busy && !sar_done ##1 !DONE_IRQ)
        else $error("disable did not stop conversion");
    chk_start_clear: assert property (start_q |=> !start_q || $past(wr_cr1))
        else $error("start bit did not clear");
    chk_end_clear: assert property (rd_dr1 && !sar_done && !STANDBY |=> !end_q)
        else $error("end flag not cleared by upper read");
    chk_busy_track: assert property (kick && !sar_abort |=> sar_busy)
        else $error("busy not set at start");
    chk_done_group: assert property (sar_done && !STANDBY |=> DONE_IRQ && end_q && res_q == $past(sar_result))
        else $error("completion effects not together");

    cov_soft_done: cover property (sar_done && mode_q == `ADSQ_MODE_SOFT);
    cov_repeat: cover property (restart_q ##1 sar_busy);
    cov_standby_busy: cover property (sar_busy && STANDBY);
    cov_read_after_done: cover property (end_q && rd_dr1);
endmodule

// ---- testbench/adsq_analog_model.sv ----
// Analog source and comparator model facing the converter control block
`timescale 1ns/10ps
module adsq_analog_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [9:0] base_level,
    input wire logic [3:0] ch_sel,
    input wire logic sample,
    input wire logic [9:0] dac_code,
    output logic comp
);
    logic [9:0] held_q;

    // ==========================================================
    // Sample and hold
    // Level is frozen after sampling; the bench keeps pins quiet meanwhile
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            held_q <= 10'h000;
        else if (sample)
            held_q <= base_level ^ {6'h00, ch_sel};
    end

    // Ideal comparator, so a correct search lands on the held level
    assign comp = (held_q >= dac_code);
endmodule

// ---- testbench/adsq_top_bench.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module adsq_top_bench;
    logic clk;
    logic rst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic standby;
    logic comp;
    logic [3:0] ch_sel;
    logic [9:0] dac_code;
    logic sample;
    logic ladder_on;
    logic done_irq;
    logic ain_disable;
    logic [9:0] base_level;
    int mismatches;
    int check_count;
    int cyc;
    int n;

    // ==========================================================
    // Design and far side
    adsq_top dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .STANDBY(standby), .COMP(comp), .CH_SEL(ch_sel), .AIN_DISABLE(ain_disable), .DAC_CODE(dac_code),
        .SAMPLE(sample), .LADDER_ON(ladder_on), .DONE_IRQ(done_irq));
    adsq_analog_model src (.clk(clk), .rst(rst), .base_level(base_level), .ch_sel(ch_sel),
        .sample(sample), .dac_code(dac_code), .comp(comp));

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data are taken one cycle after the strobe, their only valid cycle
    task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check({2'b00, rdata}, {2'b00, exp});
    endtask

    // Bounded wait; n equals limit when no request came
    task automatic wait_irq(input int limit, output int cnt);
        cnt = 0;
        while (cnt < limit)
        begin
            @(posedge clk);
            #1;
            cnt++;
            if (done_irq === 1'b1)
                return;
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_reset;
        expect_reg(8'h0e, 8'h00);
        expect_reg(8'h0f, 8'h00);
        expect_reg(8'h1e, 8'h00);
        expect_reg(8'h10, 8'h00);
        $display("reset test done");
    endtask

    task automatic test_soft;
        logic [9:0] v;
        v = 10'h2a5 ^ 10'h003;
        base_level <= 10'h2a5;
        wr_reg(8'h0f, 8'h00);
        wr_reg(8'h0e, 8'ha3);
        @(posedge clk);
        expect_reg(8'h1e, 8'h10);
        wait_irq(60, n);
        check(10'(n >= 36 && n <= 42), 10'h001);
        check({6'h00, ch_sel}, 10'h003);
        expect_reg(8'h0e, 8'h23);
        expect_reg(8'h1e, {v[1:0], 6'h20});
        expect_reg(8'h1f, v[9:2]);
        expect_reg(8'h1e, {v[1:0], 6'h00});
        $display("soft conversion test done");
    endtask

    task automatic test_repeat;
        logic [9:0] v;
        v = 10'h155 ^ 10'h005;
        base_level <= 10'h155;
        wr_reg(8'h0e, 8'he5);
        wait_irq(60, n);
        wait_irq(60, n);
        check(10'(n < 60), 10'h001);
        // New level reaches the next sample, so a stored partial would differ
        base_level <= 10'h0aa;
        repeat (15) @(posedge clk);
        wr_reg(8'h0e, 8'h00);
        wait_irq(100, n);
        check(10'(n), 10'd100);
        expect_reg(8'h1f, v[9:2]);
        expect_reg(8'h1e, {v[1:0], 6'h00});
        $display("repeat and disable test done");
    endtask

    // Slower time select, ladder only while converting, and mode 10 refusing a start
    task automatic test_slow;
        logic [9:0] v;
        v = 10'h3c0 ^ 10'h001;
        base_level <= 10'h3c0;
        wr_reg(8'h0f, 8'h04);
        wr_reg(8'h0e, 8'ha1);
        repeat (20) @(posedge clk);
        #1;
        check({9'h000, ladder_on}, 10'h001);
        // Select 010 is 78 cycles; three more for start and completion latency
        wait_irq(120, n);
        check(10'(n + 20 >= 78 && n + 20 <= 82), 10'h001);
        check({9'h000, ladder_on}, 10'h000);
        // Handler path with the latch lost: end flag alone shows completion
        // No higher-priority source exists here, so the direct call keeps order
        expect_reg(8'h1e, {v[1:0], 6'h20});
        expect_reg(8'h1f, v[9:2]);
        wr_reg(8'h0e, 8'hc1);
        expect_reg(8'h1e, {v[1:0], 6'h00});
        $display("slow timing test done");
    endtask

    task automatic test_standby;
        wr_reg(8'h0f, 8'h20);
        wr_reg(8'h0e, 8'hb7);
        repeat (15) @(posedge clk);
        #1;
        check({8'h00, ladder_on, ain_disable}, 10'h003);
        standby <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check({8'h00, ladder_on, sample}, 10'h000);
        check(dac_code, 10'h000);
        check({9'h000, ain_disable}, 10'h000);
        wr_reg(8'h0f, 8'h20);
        standby <= 1'b0;
        expect_reg(8'h0e, 8'h00);
        expect_reg(8'h0f, 8'h00);
        expect_reg(8'h1f, 8'h00);
        expect_reg(8'h1e, 8'h00);
        wait_irq(100, n);
        check(10'(n), 10'd100);
        check({8'h00, ladder_on, sample}, 10'h000);
        $display("standby test done");
    endtask

    // ==========================================================
    // Clock, watchdog and main sequence
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Cuts a hang short well above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        standby = 1'b0;
        base_level = 10'h000;
        mismatches = 0;
        check_count = 0;
        cyc = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_soft();
        test_repeat();
        test_slow();
        test_standby();
        give_verdict();
    end
endmodule
